// File: xim_pkg.sv
// package for the extension interrupt multiplexer with hardware trap tracking
// assumes one system clock domain; shared by the select slice and the top level
package xim_pkg;

	// register indices on the local access port
	localparam logic [3:0] IDX_SEL0      = 4'h0;
	localparam logic [3:0] IDX_SEL3      = 4'h3;
	localparam logic [3:0] IDX_TRAP_FLAG = 4'h4;
	localparam logic [3:0] IDX_VCTL0     = 4'h5;
	localparam logic [3:0] IDX_VCTL3     = 4'h8;

	// select register layout: enables high byte, flags low byte
	localparam int SEL_EN_LSB   = 8;
	localparam int SEL_EN_MSB   = 15;
	localparam int SEL_FLAG_LSB = 0;
	localparam int SEL_FLAG_MSB = 7;

	// per-vector control register layout
	localparam int VCTL_LVL_LSB = 0;
	localparam int VCTL_LVL_MSB = 3;
	localparam int VCTL_IE_BIT  = 6;
	localparam int VCTL_IR_BIT  = 7;

	// reset values
	localparam logic [15:0] SEL_RST       = 16'h0000;
	localparam logic [15:0] VCTL_RST      = 16'h0000;
	localparam logic [7:0]  TRAP_FLAG_RST = 8'h00;

	// shared vector placement: word spaced locations, consecutive trap numbers
	localparam logic [23:0] SHARED_VEC_BASE  = 24'h000100;
	localparam logic [23:0] SHARED_VEC_STEP  = 24'h000004;
	localparam logic [7:0]  SHARED_TRAP_BASE = 8'h40;

	// hardware trap vectors: index 0 is the highest priority
	localparam int          TRAP_COUNT     = 8;
	localparam logic [23:0] TRAP_VEC_BASE  = 24'h000008;
	localparam logic [23:0] TRAP_VEC_STEP  = 24'h000008;
	localparam logic [7:0]  TRAP_NUM_BASE  = 8'h02;
	localparam logic [7:0]  TRAP_NUM_STEP  = 8'h02;

	// access request from the cpu side of the miscellaneous area
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  idx;
		logic [15:0] wdata;
	} xim_acc_s;

endpackage

// File: xim_sel_slice.sv
// one select register with its sources and the shared request it builds
// assumes event inputs are one-cycle pulses from logic on the same clock
`timescale 1ns/100ps

module xim_sel_slice (
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [7:0]  src_evt_i,
	input  wire logic        wr_i,
	input  wire logic [15:0] wdata_i,
	output logic [15:0]      sel_o,
	output logic             req_o
);

	logic [15:0] sel_reg;
	logic [15:0] sel_next;

	////////////////////////////////////////////////////////////////////////
	// next value: enables are plain storage, flags clear on written zeros
	always_comb begin
		sel_next = sel_reg;
		if (wr_i) begin
			sel_next[xim_pkg::SEL_EN_MSB:xim_pkg::SEL_EN_LSB] =
				wdata_i[xim_pkg::SEL_EN_MSB:xim_pkg::SEL_EN_LSB];
			sel_next[xim_pkg::SEL_FLAG_MSB:xim_pkg::SEL_FLAG_LSB] =
				sel_reg[xim_pkg::SEL_FLAG_MSB:xim_pkg::SEL_FLAG_LSB]
				& wdata_i[xim_pkg::SEL_FLAG_MSB:xim_pkg::SEL_FLAG_LSB];
		end
		// events set flags after the clear so a clashing event is kept
		sel_next[xim_pkg::SEL_FLAG_MSB:xim_pkg::SEL_FLAG_LSB] =
			sel_next[xim_pkg::SEL_FLAG_MSB:xim_pkg::SEL_FLAG_LSB] | src_evt_i;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sel_reg <= xim_pkg::SEL_RST;
		end else begin
			sel_reg <= sel_next;
		end
	end

	// one request for all enabled flags; masked flags stay pollable only
	assign req_o = |(sel_reg[xim_pkg::SEL_FLAG_MSB:xim_pkg::SEL_FLAG_LSB]
		& sel_reg[xim_pkg::SEL_EN_MSB:xim_pkg::SEL_EN_LSB]);
	assign sel_o = sel_reg;

	////////////////////////////////////////////////////////////////////////
	// checks
	a_flag_catch_evt: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		src_evt_i[0] |=> sel_o[xim_pkg::SEL_FLAG_LSB])
		else $error("event did not set its flag");
	a_flag_write_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		wr_i && !wdata_i[0] && !src_evt_i[0] |=> !sel_o[xim_pkg::SEL_FLAG_LSB])
		else $error("flag not cleared by written zero");
	a_req_from_mask: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		src_evt_i[1] && sel_o[9] && !wr_i |=> req_o)
		else $error("enabled event raised no request");

endmodule

// File: xim_top.sv
// extension interrupt multiplexer: four shared vectors, hardware trap flags
// assumes cpu, peripherals and trap sources all run on sys_clk_i
// Summary of operation
// - four 16-bit select registers, one per shared vector, each its own slice
// - select high byte holds one enable bit per multiplexed source
// - enable byte masks which sources may raise the shared vector
// - several enabled sources give one request; software reads flags to tell them apart
// - a flag records its event even while its enable is clear
// - registers reachable only with both area and bus enables set
// - shared vectors at consecutive word locations with consecutive trap numbers
// - a hardware trap cannot be masked and branches to its own vector
// - each hardware trap sets its own bit in the trap flag register
// - a trap preempts anything unless a trap of equal or higher priority is in service
// - no standard interrupt or event transfer interrupts a trap service
// - each shared vector has a control register: request, enable, 16-level priority
`timescale 1ns/100ps

module xim_top #(
	parameter int NUM_VEC = 4
) (
	input  wire logic                   sys_clk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   misc_area_access_enable_i,
	input  wire logic                   ext_periph_bus_enable_i,
	input  wire xim_pkg::xim_acc_s      acc_i,
	output logic [15:0]                 rd_data_o,
	input  wire logic [NUM_VEC*8-1:0]   src_evt_i,
	input  wire logic [7:0]             trap_evt_i,
	input  wire logic                   trap_ack_i,
	input  wire logic                   trap_done_i,
	output logic                        trap_req_o,
	output logic [7:0]                  trap_num_o,
	output logic [23:0]                 trap_vec_o,
	output logic [NUM_VEC-1:0]          shared_vector_o,
	input  wire logic                   irq_ack_i,
	output logic                        irq_req_o,
	output logic [7:0]                  irq_trap_num_o,
	output logic [23:0]                 irq_vec_o,
	output logic [3:0]                  irq_level_o
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// lowest set bit wins: trap index 0 is the most urgent
	function automatic logic [3:0] first_set(input logic [7:0] v);
		logic [3:0] r;
		r = 4'h8;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// access gating

	logic        acc_ok;
	logic        wr_ok;
	logic [15:0] sel_q [NUM_VEC];
	logic [NUM_VEC-1:0] slice_wr;

	// both enables must be on, otherwise the area is invisible
	assign acc_ok = misc_area_access_enable_i & ext_periph_bus_enable_i;
	assign wr_ok  = acc_i.wr & acc_ok;

	////////////////////////////////////////////////////////////////////////
	// select register slices, one replicated structure per vector

	for (genvar g = 0; g < NUM_VEC; g++) begin : g_vec
		assign slice_wr[g] = wr_ok && (acc_i.idx == 4'(g));
		xim_sel_slice u_slice (
			.sys_clk_i (sys_clk_i),
			.sys_rst_i (sys_rst_i),
			.src_evt_i (src_evt_i[g*8 +: 8]),
			.wr_i      (slice_wr[g]),
			.wdata_i   (acc_i.wdata),
			.sel_o     (sel_q[g]),
			.req_o     (shared_vector_o[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// per-vector control: request flag, enable flag, priority level

	logic [15:0]        vctl_reg [NUM_VEC];
	logic [15:0]        vctl_next [NUM_VEC];
	logic [NUM_VEC-1:0] shared_prev_reg;
	logic [NUM_VEC-1:0] shared_prev_next;
	logic [1:0]         irq_idx_reg;
	logic [1:0]         irq_idx_next;
	logic               irq_req_reg;
	logic               irq_req_next;
	logic [3:0]         irq_lvl_reg;
	logic [3:0]         irq_lvl_next;
	logic [7:0]         trap_isr_reg;

	// request flag sets on a rising shared request, so an unserviced level
	// does not refire after acknowledge; set wins over clear
	always_comb begin
		shared_prev_next = shared_vector_o;
		for (int v = 0; v < NUM_VEC; v++) begin
			vctl_next[v] = vctl_reg[v];
			if (wr_ok && acc_i.idx == 4'(v + 5)) begin
				vctl_next[v] = acc_i.wdata;
			end
			if (irq_ack_i && irq_req_reg && irq_idx_reg == 2'(v)) begin
				vctl_next[v][xim_pkg::VCTL_IR_BIT] = 1'b0;
			end
			if (shared_vector_o[v] && !shared_prev_reg[v]) begin
				vctl_next[v][xim_pkg::VCTL_IR_BIT] = 1'b1;
			end
			vctl_next[v][15:8] = 8'h00;
			vctl_next[v][5:4]  = 2'h0;
		end
	end

	// arbitration: highest level wins, lower vector breaks ties
	logic       arb_found;
	logic [1:0] arb_idx;
	logic [3:0] arb_lvl;
	always_comb begin
		arb_found = 1'b0;
		arb_idx   = 2'h0;
		arb_lvl   = 4'h0;
		for (int v = 0; v < NUM_VEC; v++) begin
			if (vctl_reg[v][xim_pkg::VCTL_IR_BIT] && vctl_reg[v][xim_pkg::VCTL_IE_BIT] &&
				(!arb_found ||
				vctl_reg[v][xim_pkg::VCTL_LVL_MSB:xim_pkg::VCTL_LVL_LSB] > arb_lvl)) begin
				arb_found = 1'b1;
				arb_idx   = 2'(v);
				arb_lvl   = vctl_reg[v][xim_pkg::VCTL_LVL_MSB:xim_pkg::VCTL_LVL_LSB];
			end
		end
		// a trap service shuts out every ordinary request and event transfer
		// the acknowledge cycle of a trap is shut out too, so no request shows in its first cycle
		irq_req_next = arb_found && (trap_isr_reg == 8'h00) && !irq_ack_i && !trap_ack_i;
		irq_idx_next = arb_idx;
		irq_lvl_next = arb_lvl;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int v = 0; v < NUM_VEC; v++) begin
				vctl_reg[v] <= xim_pkg::VCTL_RST;
			end
			shared_prev_reg <= '0;
			irq_req_reg     <= 1'b0;
			irq_idx_reg     <= 2'h0;
			irq_lvl_reg     <= 4'h0;
		end else begin
			for (int v = 0; v < NUM_VEC; v++) begin
				vctl_reg[v] <= vctl_next[v];
			end
			shared_prev_reg <= shared_prev_next;
			irq_req_reg     <= irq_req_next;
			irq_idx_reg     <= irq_idx_next;
			irq_lvl_reg     <= irq_lvl_next;
		end
	end

	// consecutive word-spaced locations and trap numbers
	assign irq_req_o      = irq_req_reg;
	assign irq_level_o    = irq_lvl_reg;
	assign irq_vec_o      = xim_pkg::SHARED_VEC_BASE
		+ 24'(irq_idx_reg) * xim_pkg::SHARED_VEC_STEP;
	assign irq_trap_num_o = xim_pkg::SHARED_TRAP_BASE + 8'(irq_idx_reg);

	////////////////////////////////////////////////////////////////////////
	// hardware traps: flags, pending, nested in-service stack

	logic [7:0] trap_flag_reg;
	logic [7:0] trap_flag_next;
	logic [7:0] trap_pend_reg;
	logic [7:0] trap_pend_next;
	logic [7:0] trap_isr_next;
	logic       trap_req_reg;
	logic       trap_req_next;
	logic [2:0] trap_idx_reg;
	logic [2:0] trap_idx_next;
	logic [3:0] pend_top;
	logic [3:0] isr_top;

	// no mask exists for traps: every event is flagged and becomes pending
	always_comb begin
		trap_flag_next = trap_flag_reg;
		trap_pend_next = trap_pend_reg;
		trap_isr_next  = trap_isr_reg;
		if (wr_ok && acc_i.idx == xim_pkg::IDX_TRAP_FLAG) begin
			trap_flag_next = trap_flag_reg & acc_i.wdata[7:0];
		end
		if (trap_done_i) begin
			// the most urgent service in progress is the one returning
			trap_isr_next = trap_isr_reg & (trap_isr_reg - 8'h01);
		end
		if (trap_ack_i && trap_req_reg) begin
			trap_pend_next[trap_idx_reg] = 1'b0;
			trap_isr_next[trap_idx_reg]  = 1'b1;
		end
		trap_flag_next = trap_flag_next | trap_evt_i;
		trap_pend_next = trap_pend_next | trap_evt_i;
		pend_top = first_set(trap_pend_reg);
		isr_top  = first_set(trap_isr_reg);
		// preempt only when strictly more urgent than the running service
		trap_req_next = (pend_top < isr_top) && !(trap_ack_i && trap_req_reg);
		trap_idx_next = pend_top[2:0];
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			trap_flag_reg <= xim_pkg::TRAP_FLAG_RST;
			trap_pend_reg <= 8'h00;
			trap_isr_reg  <= 8'h00;
			trap_req_reg  <= 1'b0;
			trap_idx_reg  <= 3'h0;
		end else begin
			trap_flag_reg <= trap_flag_next;
			trap_pend_reg <= trap_pend_next;
			trap_isr_reg  <= trap_isr_next;
			trap_req_reg  <= trap_req_next;
			trap_idx_reg  <= trap_idx_next;
		end
	end

	// each trap has its own dedicated vector location and number
	assign trap_req_o = trap_req_reg;
	assign trap_vec_o = xim_pkg::TRAP_VEC_BASE
		+ 24'(trap_idx_reg) * xim_pkg::TRAP_VEC_STEP;
	assign trap_num_o = xim_pkg::TRAP_NUM_BASE
		+ 8'(trap_idx_reg) * xim_pkg::TRAP_NUM_STEP;

	////////////////////////////////////////////////////////////////////////
	// read port: one cycle latency, zero when the area is closed

	logic [15:0] rd_data_reg;
	logic [15:0] rd_data_next;
	always_comb begin
		rd_data_next = 16'h0000;
		if (acc_i.rd && acc_ok) begin
			if (acc_i.idx <= xim_pkg::IDX_SEL3) begin
				rd_data_next = sel_q[acc_i.idx[1:0]];
			end else if (acc_i.idx == xim_pkg::IDX_TRAP_FLAG) begin
				rd_data_next = {8'h00, trap_flag_reg};
			end else if (acc_i.idx >= xim_pkg::IDX_VCTL0 && acc_i.idx <= xim_pkg::IDX_VCTL3) begin
				rd_data_next = vctl_reg[2'(acc_i.idx - xim_pkg::IDX_VCTL0)];
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_data_reg <= 16'h0000;
		end else begin
			rd_data_reg <= rd_data_next;
		end
	end
	assign rd_data_o = rd_data_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_closed_write;
		acc_i.wr && !acc_ok && acc_i.idx == xim_pkg::IDX_SEL0;
	endsequence
	sequence s_lone_trap0;
		trap_evt_i[0] && trap_isr_reg == 8'h00 && !trap_ack_i;
	endsequence

	a_gate_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		s_closed_write and src_evt_i[7:0] == 8'h00 |=> $stable(sel_q[0]))
		else $error("write landed while area closed");
	a_gate_read: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		acc_i.rd && !acc_ok |=> rd_data_o == 16'h0000)
		else $error("read returned data while area closed");
	a_trap_flag_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		trap_evt_i[3] |=> trap_flag_reg[3])
		else $error("trap did not set its flag");
	a_trap_raised: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		s_lone_trap0 ##1 !trap_ack_i |=> trap_req_o && trap_vec_o == xim_pkg::TRAP_VEC_BASE)
		else $error("unmasked trap not requested");
	a_trap_no_preempt: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		trap_isr_reg[0] |=> !trap_req_o)
		else $error("trap requested over most urgent service");
	a_trap_blocks_irq: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$past(trap_isr_reg) != 8'h00 |-> !irq_req_o)
		else $error("ordinary request during trap service");
	a_ack_blocks_irq: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		trap_ack_i |=> !irq_req_o)
		else $error("ordinary request offered on trap acknowledge");
	a_vec_place: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		irq_req_o && irq_vec_o[15:0] == 16'h010C |-> irq_trap_num_o == 8'h43)
		else $error("shared vector location and number disagree");
	a_ir_from_req: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$rose(shared_vector_o[1]) |=> vctl_reg[1][xim_pkg::VCTL_IR_BIT])
		else $error("shared request did not set request flag");

endmodule

// File: xim_cpu_model.sv
// behavioural cpu side for the extension interrupt multiplexer: takes traps and requests
// assumes one system clock; ack and done pulses launch 1 ns after the rising edge
`timescale 1ns/100ps

module xim_cpu_model (
	input  wire logic        sys_clk_i,
	input  wire logic        trap_req_i,
	input  wire logic [7:0]  trap_num_i,
	input  wire logic [23:0] trap_vec_i,
	input  wire logic        irq_req_i,
	input  wire logic [7:0]  irq_num_i,
	input  wire logic [23:0] irq_vec_i,
	input  wire logic [3:0]  irq_lvl_i,
	output logic             trap_ack_o,
	output logic             trap_done_o,
	output logic             irq_ack_o
);
	int          ack_dly  = 0;
	int          svc_len  = 3;
	int          trap_cnt = 0;
	int          irq_cnt  = 0;
	int          bad_irq  = 0;
	int          wt       = 0;
	int          svc[$];
	logic        tr, ir, ta, ia;
	logic        dn, nta, nia;
	logic [7:0]  t_num, i_num;
	logic [23:0] t_vec, i_vec;
	logic [3:0]  i_lvl;

	initial begin
		trap_ack_o  = 1'b0;
		trap_done_o = 1'b0;
		irq_ack_o   = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// nested services end newest first, so done always refers to the top of the stack
	always @(posedge sys_clk_i) begin
		tr = trap_req_i;
		ir = irq_req_i;
		ta = trap_ack_o;
		ia = irq_ack_o;
		// an ordinary request seen inside a trap service is counted as a fault
		if (svc.size() > 0 && !ta && ir)
			bad_irq++;
		#1;
		// outputs are worked out first and driven once, so no pulse glitches
		dn  = 1'b0;
		nta = 1'b0;
		nia = 1'b0;
		if (svc.size() > 0) begin
			svc[$]--;
			if (svc[$] <= 0) begin
				dn = 1'b1;
				void'(svc.pop_back());
			end
		end
		// ack only while offered, never twice on one offer, optionally late
		if (!dn && tr && !ta) begin
			if (wt >= ack_dly) begin
				nta = 1'b1;
				trap_cnt++;
				t_num = trap_num_i;
				t_vec = trap_vec_i;
				svc.push_back(svc_len);
				wt = 0;
			end else
				wt++;
		end else if (ir && !ia && svc.size() == 0) begin
			nia = 1'b1;
			irq_cnt++;
			i_num = irq_num_i;
			i_vec = irq_vec_i;
			i_lvl = irq_lvl_i;
		end
		trap_ack_o  = nta;
		irq_ack_o   = nia;
		trap_done_o = dn;
	end
endmodule

// File: tb_top.sv
// self-checking bench for the extension interrupt multiplexer and trap logic
// assumes xim_pkg and xim_top compiled first; cpu side modelled by xim_cpu_model
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb_top;
	logic              sys_clk = 1'b0, sys_rst = 1'b1, men = 1'b0, pen = 1'b0, rd_q = 1'b0;
	logic              trap_ack, trap_done, irq_ack, trap_req, irq_req;
	xim_pkg::xim_acc_s acc = '0;
	logic [31:0]       src_evt = '0;
	logic [7:0]        trap_evt = '0, trap_num, irq_num, en, ev;
	logic [23:0]       trap_vec, irq_vec;
	logic [3:0]        irq_lvl, shv, lvl;
	logic [15:0]       rd_data, ex;
	logic [15:0]       exp_q[$];
	int                mismatches = 0, comparisons = 0, n, ni;

	always #25 sys_clk = ~sys_clk;

	xim_top DUT (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .misc_area_access_enable_i(men),
		.ext_periph_bus_enable_i(pen), .acc_i(acc), .rd_data_o(rd_data), .src_evt_i(src_evt),
		.trap_evt_i(trap_evt), .trap_ack_i(trap_ack), .trap_done_i(trap_done),
		.trap_req_o(trap_req), .trap_num_o(trap_num), .trap_vec_o(trap_vec),
		.shared_vector_o(shv), .irq_ack_i(irq_ack), .irq_req_o(irq_req),
		.irq_trap_num_o(irq_num), .irq_vec_o(irq_vec), .irq_level_o(irq_lvl));

	xim_cpu_model cpu (.sys_clk_i(sys_clk), .trap_req_i(trap_req), .trap_num_i(trap_num),
		.trap_vec_i(trap_vec), .irq_req_i(irq_req), .irq_num_i(irq_num), .irq_vec_i(irq_vec),
		.irq_lvl_i(irq_lvl), .trap_ack_o(trap_ack), .trap_done_o(trap_done), .irq_ack_o(irq_ack));

	////////////////////////////////////////////////////////////////////////////////
	// read data stands one cycle after the strobe; oldest note is compared then
	always @(posedge sys_clk) begin
		if (rd_q) begin
			ex = exp_q.pop_front();
			`CHK("rd_data_o", ex, rd_data)
		end
		rd_q <= acc.rd;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one register access, strobe held exactly one cycle
	task acc_op(input logic w, input logic [3:0] i, input logic [15:0] d);
		@(posedge sys_clk);
		#1 acc.wr = w;
		acc.rd = !w;
		acc.idx = i;
		acc.wdata = d;
		@(posedge sys_clk);
		#1 acc = '0;
	endtask

	task rd(input logic [3:0] i, input logic [15:0] e);
		exp_q.push_back(e);
		acc_op(1'b0, i, 16'h0000);
	endtask

	task evt(input logic [31:0] s, input logic [7:0] t);
		@(posedge sys_clk);
		#1 src_evt = s;
		trap_evt = t;
		@(posedge sys_clk);
		#1 src_evt = '0;
		trap_evt = '0;
	endtask

	// bounded wait until the cpu model has taken n traps or n requests
	task wt(input logic tr, input int c);
		for (int i = 0; i < 300 && (tr ? cpu.trap_cnt : cpu.irq_cnt) < c; i++)
			@(posedge sys_clk);
		`CHK("taken count", c, (tr ? cpu.trap_cnt : cpu.irq_cnt))
	endtask

	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// watchdog: whole run is a few hundred cycles, limit is 20000 cycles
	initial begin
		#(50 * 20000);
		mismatches++;
		end_of_test;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(40830));
		repeat (12) @(posedge sys_clk);
		`CHK("irq_vec_o", 24'h000100, irq_vec)
		`CHK("trap_vec_o", 24'h000008, trap_vec)
		#1 sys_rst = 1'b0;
		men = 1'b1;
		pen = 1'b1;
		// reset values, and unmapped places read zero
		for (int i = 0; i < 16; i++)
			rd(i[3:0], 16'h0000);
		// writes refused while either enable is low
		men = 1'b0;
		acc_op(1'b1, 4'h0, 16'hFF00);
		men = 1'b1;
		rd(4'h0, 16'h0000);
		pen = 1'b0;
		acc_op(1'b1, 4'h1, 16'hFF00);
		pen = 1'b1;
		rd(4'h0, 16'h0000);
		rd(4'h1, 16'h0000);
		// an open write lands, yet a closed read of it still shows zero
		acc_op(1'b1, 4'h1, 16'hFF00);
		pen = 1'b0;
		rd(4'h1, 16'h0000);
		pen = 1'b1;
		rd(4'h1, 16'hFF00);
		// each shared vector reaches the cpu at its own location and level
		for (int g = 0; g < 4; g++) begin
			lvl = 4'($urandom);
			n = cpu.irq_cnt + 1;
			acc_op(1'b1, 4'h5 + g[3:0], {10'h001, 2'b00, lvl});
			// two enabled sources fire together: one request, both flags readable
			acc_op(1'b1, g[3:0], 16'h0300);
			evt(32'h3 << (8 * g), 8'h00);
			wt(1'b0, n);
			rd(g[3:0], 16'h0303);
			`CHK("irq vec", 24'h000100 + 24'(4 * g), cpu.i_vec)
			`CHK("irq num", 8'h40 + 8'(g), cpu.i_num)
			`CHK("irq lvl", lvl, cpu.i_lvl)
			acc_op(1'b1, g[3:0], 16'h0000);
			acc_op(1'b1, 4'h5 + g[3:0], 16'h0000);
		end
		// random masks and events; written 1 keeps a flag, 0 clears it
		for (int g = 0; g < 4; g++) begin
			en = 8'($urandom);
			ev = 8'($urandom);
			acc_op(1'b1, g[3:0], {en, 8'hFF});
			evt({24'h0, ev} << (8 * g), 8'h00);
			rd(g[3:0], {en, ev});
			`CHK("shared_vector_o", |(en & ev), shv[g])
			acc_op(1'b1, g[3:0], {en, 8'h0F});
			rd(g[3:0], {en, ev & 8'h0F});
			`CHK("shared_vector_o", |(en & ev & 8'h0F), shv[g])
			acc_op(1'b1, g[3:0], 16'h0000);
		end
		// every trap, one at a time
		for (int k = 0; k < 8; k++) begin
			n = cpu.trap_cnt + 1;
			evt(32'h0, 8'(1 << k));
			wt(1'b1, n);
			`CHK("trap vec", 24'h000008 + 24'(8 * k), cpu.t_vec)
			`CHK("trap num", 8'h02 + 8'(2 * k), cpu.t_num)
			repeat (6) @(posedge sys_clk);
			rd(4'h4, {8'h00, 8'((2 << k) - 1)});
		end
		acc_op(1'b1, 4'h4, 16'h0000);
		rd(4'h4, 16'h0000);
		// nesting with a slow cpu: a less urgent trap and a request wait
		cpu.svc_len = 20;
		cpu.ack_dly = 2;
		n = cpu.trap_cnt;
		ni = cpu.irq_cnt;
		evt(32'h0, 8'h04);
		wt(1'b1, n + 1);
		acc_op(1'b1, 4'h0, 16'h0100);
		acc_op(1'b1, 4'h5, 16'h0045);
		evt(32'h1, 8'h20);
		repeat (3) @(posedge sys_clk);
		#1 `CHK("trap_req_o", 1'b0, trap_req)
		evt(32'h0, 8'h01);
		wt(1'b1, n + 2);
		`CHK("trap num", 8'h02, cpu.t_num)
		wt(1'b1, n + 3);
		`CHK("trap num", 8'h0C, cpu.t_num)
		wt(1'b0, ni + 1);
		`CHK("irq vec", 24'h000100, cpu.i_vec)
		`CHK("requests in service", 0, cpu.bad_irq)
		end_of_test;
	end
endmodule
